// *** gain_map_pkg.sv ***
/*
  Constants, types and helpers for the time-varying gain map register bank:
  register indices, field positions, reset values, interval table and gain math.
  Assumes a single 25 MHz clock domain and an AXI4-Lite register port with
  32-bit data, one register per aligned word at byte address four times index.
*/
// Behaviour
// - deltas_a upper nibble: interval point one-two
// - deltas_a lower nibble: interval point two-three
// - deltas_b upper nibble: interval point three-four
// - deltas_b lower nibble: interval point four-five
// - delta codes map to sixteen fixed microsecond intervals
// - points_a bits 7:2 hold point one gain
// - point two gain split across points_a, points_b
// - points_b lower nibble holds point three bits
// - gain is half dB times code+1 plus range
// - deltas_b 16h, points_a 17h, points_b 18h, reset zero
// - start register 14h: start code, first delta
// - deltas_a at 15h, resets to zero
// - points_c bits 7:6 hold remaining point three bits
package gain_map_pkg;

  // ---------------------------------------------------------------
  // clock and bus
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          NS_PER_US     = 1000;
  localparam int          TICKS_PER_US  = NS_PER_US / CLK_PERIOD_NS;
  localparam int          ADDR_W        = 8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [5:0]  IDX_START     = 6'h14;
  localparam logic [5:0]  IDX_DELTAS_A  = 6'h15;
  localparam logic [5:0]  IDX_DELTAS_B  = 6'h16;
  localparam logic [5:0]  IDX_POINTS_A  = 6'h17;
  localparam logic [5:0]  IDX_POINTS_B  = 6'h18;
  localparam logic [5:0]  IDX_POINTS_C  = 6'h19;
  localparam logic [5:0]  IDX_RANGE     = 6'h20;
  localparam logic [5:0]  IDX_CONTROL   = 6'h21;
  localparam logic [5:0]  IDX_STATUS    = 6'h22;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          NIB_HI_LSB    = 4;
  localparam int          NIB_LO_LSB    = 0;
  localparam int          G1_LSB        = 2;
  localparam int          G3_TAIL_LSB   = 6;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_ABORT    = 1;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_PT_LSB   = 4;
  localparam logic [2:0]  LAST_GAIN_PT  = 3'h3;
  localparam logic [2:0]  LAST_SEG      = 3'h5;

  // ---------------------------------------------------------------
  // interval table in microseconds, code 0 first
  // ---------------------------------------------------------------
  localparam logic [12:0] DELTA_US [0:15] = '{
    13'h0064, 13'h00C8, 13'h012C, 13'h0190, 13'h0258, 13'h0320, 13'h03E8, 13'h04B0,
    13'h0578, 13'h07D0, 13'h0960, 13'h0C80, 13'h0FA0, 13'h1450, 13'h1900, 13'h1F40};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] gain_map_start_code;
    logic [3:0] gain_delta_zero_one;
    logic [3:0] gain_delta_one_two;
    logic [3:0] gain_delta_two_three;
    logic [3:0] gain_delta_three_four;
    logic [3:0] gain_delta_four_five;
    logic [5:0] gain_point_one_code;
    logic [5:0] gain_point_two_code;
    logic [5:0] gain_point_three_code;
    logic [7:0] front_end_gain_range;
  } gain_map_cfg_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] delta_us(input logic [3:0] code);
    delta_us = DELTA_US[code];
  endfunction : delta_us

  // result in half-dB steps; range offset also held in half-dB steps
  function automatic logic [8:0] gain_half_db(input logic [5:0] code,
                                              input logic [7:0] range);
    gain_half_db = {3'h0, code} + 9'h001 + {1'b0, range};
  endfunction : gain_half_db

endpackage : gain_map_pkg

// *** gain_map_regs.sv ***
/*
  Time-varying gain map register bank with an AXI4-Lite slave and a small
  sequencer that walks the map points and drives the current gain code.
  Assumes a well-behaved AXI4-Lite master (one write and one read at a time)
  and a single clock with asynchronous active-low reset.
*/
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
module gain_map_regs #(
  parameter int TICKS_PER_US = gain_map_pkg::TICKS_PER_US
) (
  input  wire logic                              CLK,
  input  wire logic                              RESET_N,
  input  wire logic [gain_map_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                              S_AXI_AWVALID,
  output logic                                   S_AXI_AWREADY,
  input  wire logic [31:0]                       S_AXI_WDATA,
  input  wire logic [3:0]                        S_AXI_WSTRB,
  input  wire logic                              S_AXI_WVALID,
  output logic                                   S_AXI_WREADY,
  output logic [1:0]                             S_AXI_BRESP,
  output logic                                   S_AXI_BVALID,
  input  wire logic                              S_AXI_BREADY,
  input  wire logic [gain_map_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                              S_AXI_ARVALID,
  output logic                                   S_AXI_ARREADY,
  output logic [31:0]                            S_AXI_RDATA,
  output logic [1:0]                             S_AXI_RRESP,
  output logic                                   S_AXI_RVALID,
  input  wire logic                              S_AXI_RREADY,
  output logic [8:0]                             GAIN_HALF_DB,
  output logic [2:0]                             GAIN_POINT,
  output logic                                   GAIN_ACTIVE
);
  import gain_map_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]          gain_map_start_reg;
  logic [7:0]          gain_map_deltas_a;
  logic [7:0]          gain_map_deltas_b;
  logic [7:0]          gain_map_points_a;
  logic [7:0]          gain_map_points_b;
  logic [1:0]          gain_map_points_c;
  logic [7:0]          gain_range_reg;
  gain_map_cfg_t       cfg;

  // write channel holding
  logic                aw_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic                w_held;
  logic [7:0]          w_data;
  logic                w_lane0;
  logic                do_write;
  logic [5:0]          wr_idx;
  logic                wr_hit;
  logic                start_pulse;
  logic                abort_pulse;

  // read side
  logic [5:0]          rd_idx;
  logic [7:0]          next_rdata;
  logic                rd_hit;

  // sequencer
  seq_state_t          state;
  logic [2:0]          seg;
  logic [$clog2(TICKS_PER_US+1)-1:0] prescale;
  logic [12:0]         us_cnt;
  logic [12:0]         seg_len;
  logic                us_tick;
  logic                seg_end;

  // ---------------------------------------------------------------
  // field gathering
  // ---------------------------------------------------------------
  always_comb
  begin
    cfg.gain_map_start_code   = gain_map_start_reg[NIB_HI_LSB +: 4];
    cfg.gain_delta_zero_one   = gain_map_start_reg[NIB_LO_LSB +: 4];
    cfg.gain_delta_one_two    = gain_map_deltas_a[NIB_HI_LSB +: 4];
    cfg.gain_delta_two_three  = gain_map_deltas_a[NIB_LO_LSB +: 4];
    cfg.gain_delta_three_four = gain_map_deltas_b[NIB_HI_LSB +: 4];
    cfg.gain_delta_four_five  = gain_map_deltas_b[NIB_LO_LSB +: 4];
    cfg.gain_point_one_code   = gain_map_points_a[G1_LSB +: 6];
    // earlier register carries the upper bits of a split code
    cfg.gain_point_two_code   = {gain_map_points_a[1:0],
                                 gain_map_points_b[NIB_HI_LSB +: 4]};
    cfg.gain_point_three_code = {gain_map_points_b[NIB_LO_LSB +: 4],
                                 gain_map_points_c};
    cfg.front_end_gain_range  = gain_range_reg;
  end

  // ---------------------------------------------------------------
  // write address and data, taken in either order
  // ---------------------------------------------------------------
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign wr_idx   = aw_addr[ADDR_W-1:2];
  assign wr_hit   = (wr_idx >= IDX_START && wr_idx <= IDX_POINTS_C) ||
                    wr_idx == IDX_RANGE || wr_idx == IDX_CONTROL ||
                    wr_idx == IDX_STATUS;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      S_AXI_AWREADY <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      else if (do_write)
        aw_held <= 1'b0;
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !do_write;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      w_held       <= 1'b0;
      w_data       <= REG_RESET;
      w_lane0      <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held  <= 1'b1;
        w_data  <= S_AXI_WDATA[7:0];
        w_lane0 <= S_AXI_WSTRB[0];
      end
      else if (do_write)
        w_held <= 1'b0;
      S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !do_write;
    end
  end

  // ---------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      gain_map_start_reg <= REG_RESET;
      gain_map_deltas_a  <= REG_RESET;
      gain_map_deltas_b  <= REG_RESET;
      gain_map_points_a  <= REG_RESET;
      gain_map_points_b  <= REG_RESET;
      gain_map_points_c  <= 2'h0;
      gain_range_reg     <= REG_RESET;
    end
    else if (do_write && w_lane0)
    begin
      unique case (wr_idx)
        IDX_START:    gain_map_start_reg <= w_data;
        IDX_DELTAS_A: gain_map_deltas_a  <= w_data;
        IDX_DELTAS_B: gain_map_deltas_b  <= w_data;
        IDX_POINTS_A: gain_map_points_a  <= w_data;
        IDX_POINTS_B: gain_map_points_b  <= w_data;
        IDX_POINTS_C: gain_map_points_c  <= w_data[G3_TAIL_LSB +: 2];
        IDX_RANGE:    gain_range_reg     <= w_data;
        default:      gain_range_reg     <= gain_range_reg;
      endcase
    end
  end

  // control bits are write-one strobes, never stored
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
    end
    else
    begin
      start_pulse <= do_write && w_lane0 && wr_idx == IDX_CONTROL && w_data[CTRL_START];
      abort_pulse <= do_write && w_lane0 && wr_idx == IDX_CONTROL && w_data[CTRL_ABORT];
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign rd_idx = S_AXI_ARADDR[ADDR_W-1:2];

  always_comb
  begin
    rd_hit     = 1'b1;
    next_rdata = REG_RESET;
    unique case (rd_idx)
      IDX_START:    next_rdata = gain_map_start_reg;
      IDX_DELTAS_A: next_rdata = gain_map_deltas_a;
      IDX_DELTAS_B: next_rdata = gain_map_deltas_b;
      IDX_POINTS_A: next_rdata = gain_map_points_a;
      IDX_POINTS_B: next_rdata = gain_map_points_b;
      IDX_POINTS_C: next_rdata = {gain_map_points_c, 6'h00};
      IDX_RANGE:    next_rdata = gain_range_reg;
      IDX_CONTROL:  next_rdata = REG_RESET;
      IDX_STATUS:   next_rdata = {1'b0, GAIN_POINT, 3'h0, GAIN_ACTIVE};
      default:      rd_hit     = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h00_0000, next_rdata};
        S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // map sequencer: segment 0 is the start time, 1..5 the deltas
  // ---------------------------------------------------------------
  always_comb
  begin
    seg_len = delta_us(cfg.gain_map_start_code);
    unique case (seg)
      3'h1:    seg_len = delta_us(cfg.gain_delta_zero_one);
      3'h2:    seg_len = delta_us(cfg.gain_delta_one_two);
      3'h3:    seg_len = delta_us(cfg.gain_delta_two_three);
      3'h4:    seg_len = delta_us(cfg.gain_delta_three_four);
      3'h5:    seg_len = delta_us(cfg.gain_delta_four_five);
      default: seg_len = delta_us(cfg.gain_map_start_code);
    endcase
  end

  // microsecond base so the interval table stays in its own unit
  assign us_tick = (prescale == ($bits(prescale))'(TICKS_PER_US - 1));
  assign seg_end = us_tick && (us_cnt == seg_len - 13'h0001);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state    <= SEQ_IDLE;
      seg      <= 3'h0;
      prescale <= '0;
      us_cnt   <= 13'h0000;
    end
    else if (abort_pulse)
      state <= SEQ_IDLE;
    else if (start_pulse)
    begin
      state    <= SEQ_RUN;
      seg      <= 3'h0;
      prescale <= '0;
      us_cnt   <= 13'h0000;
    end
    else if (state == SEQ_RUN)
    begin
      prescale <= us_tick ? '0 : prescale + 1'b1;
      if (seg_end)
      begin
        us_cnt <= 13'h0000;
        seg    <= seg + 3'h1;
        if (seg == LAST_SEG)
          state <= SEQ_IDLE;
      end
      else if (us_tick)
        us_cnt <= us_cnt + 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // gain outputs; points past three have no code here, gain holds
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      GAIN_HALF_DB <= 9'h000;
      GAIN_POINT   <= 3'h0;
      GAIN_ACTIVE  <= 1'b0;
    end
    else
    begin
      GAIN_ACTIVE <= (state == SEQ_RUN) && !abort_pulse && !(seg_end && seg == LAST_SEG);
      if (start_pulse && !abort_pulse)
        GAIN_POINT <= 3'h0;
      else if (state == SEQ_RUN && seg_end && !abort_pulse)
      begin
        GAIN_POINT <= seg + 3'h1;
        unique case (seg)
          3'h0:    GAIN_HALF_DB <= gain_half_db(cfg.gain_point_one_code,
                                                cfg.front_end_gain_range);
          3'h1:    GAIN_HALF_DB <= gain_half_db(cfg.gain_point_two_code,
                                                cfg.front_end_gain_range);
          3'h2:    GAIN_HALF_DB <= gain_half_db(cfg.gain_point_three_code,
                                                cfg.front_end_gain_range);
          default: GAIN_HALF_DB <= GAIN_HALF_DB;
        endcase
      end
    end
  end

endmodule : gain_map_regs

// *** gain_map_regs_chk.sv ***
/*
  Checker bound into the gain map register bank: bus answers, map stepping.
  Assumes the ports and the TICKS_PER_US parameter of gain_map_regs.
*/
`timescale 1ns/1ns
module gain_map_regs_chk
  import gain_map_pkg::*;
#(
  parameter int TICKS_PER_US = 25
) (
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic [31:0]       S_AXI_WDATA,
  input wire logic [3:0]        S_AXI_WSTRB,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic [1:0]        S_AXI_BRESP,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic [1:0]        S_AXI_RRESP,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic [8:0]        GAIN_HALF_DB,
  input wire logic [2:0]        GAIN_POINT,
  input wire logic              GAIN_ACTIVE
);
  localparam int MIN_SEG = 100 * TICKS_PER_US;
  logic [15:0] seg_cnt;
  logic [2:0]  last_point;

  // ----------------------------------------
  // segment length, saturating so long ones stay above the floor
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      seg_cnt    <= 16'h0000;
      last_point <= 3'h0;
    end
    else
    begin
      last_point <= GAIN_POINT;
      if (GAIN_POINT != last_point)
        seg_cnt <= 16'h0001;
      else if (seg_cnt != 16'hFFFF)
        seg_cnt <= seg_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered after address taken");
  rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before taken");
  rd_unmapped_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && !(S_AXI_ARADDR[7:2] inside {[IDX_START:IDX_POINTS_C], [IDX_RANGE:IDX_STATUS]})
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  rd_mapped_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && S_AXI_ARADDR[7:2] inside {[IDX_START:IDX_POINTS_C]}
    |=> S_AXI_RRESP == RESP_OKAY && S_AXI_RDATA[31:8] == 24'h0)
    else $error("map register read refused or too wide");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY
    && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
    else $error("write not answered in time");
  wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before taken");
  pt_step_a: assert property ($changed(GAIN_POINT) && GAIN_POINT > 3'h1
    |-> GAIN_POINT == $past(GAIN_POINT) + 3'h1) else $error("map point skipped");
  seg_floor_a: assert property (GAIN_POINT != last_point && GAIN_POINT > 3'h1
    |-> seg_cnt >= MIN_SEG) else $error("segment shorter than the shortest interval");
  run_end_a: assert property ($changed(GAIN_POINT) && GAIN_POINT == 3'h6
    |-> ##[0:1] !GAIN_ACTIVE) else $error("still running after the last point");
endmodule : gain_map_regs_chk

bind gain_map_regs gain_map_regs_chk #(.TICKS_PER_US(TICKS_PER_US)) gain_map_regs_chk_inst (
  .CLK(CLK), .RESET_N(RESET_N), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .GAIN_HALF_DB(GAIN_HALF_DB), .GAIN_POINT(GAIN_POINT), .GAIN_ACTIVE(GAIN_ACTIVE));

// *** gain_map_regs_tb_top.sv ***
/*
  Bench for the gain map register bank: AXI4-Lite access, reset values,
  refused accesses and timed runs through all six map segments.
  Assumes TICKS_PER_US of 1, so one microsecond is one cycle.
*/
`timescale 1ns/1ns
`define CHK(A, E) begin total_checks++; if ((A) !== (E)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (A), (E)); end end
module gain_map_regs_tb_top;
  import gain_map_pkg::*;
  localparam int TPU = 1;
  localparam int SEG_US [0:15] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400, 2000,
                                   2400, 3200, 4000, 5200, 6400, 8000};
  logic        CLK, RESET_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY, GAIN_ACTIVE;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [8:0]  GAIN_HALF_DB;
  logic [2:0]  GAIN_POINT, last_pt;
  logic [15:0] seg_len = 16'h0000;
  logic [27:0] exp_pt;
  logic [33:0] exp_r;
  logic [1:0]  exp_b;
  logic        last_act;
  logic [1:0]  bq [$];
  logic [33:0] rq [$];
  logic [27:0] pq [$];
  int          num_errors, total_checks, seed;

  initial CLK = 1'b0;
  always #(CLK_PERIOD_NS / 2) CLK = ~CLK;

  gain_map_regs #(.TICKS_PER_US(TPU)) gain_map_regs_inst (
    .CLK(CLK), .RESET_N(RESET_N), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .GAIN_HALF_DB(GAIN_HALF_DB), .GAIN_POINT(GAIN_POINT), .GAIN_ACTIVE(GAIN_ACTIVE));

  // ----------------------------------------
  // bus master tasks; each starts one edge on so no signal is driven twice
  // ----------------------------------------
  task automatic axi_write(input logic [5:0] idx, input logic [7:0] data,
                           input logic [3:0] strb, input logic [1:0] resp);
    logic [31:0] r;
    int          n;
    r = $random(seed);
    n = 0;
    @(posedge CLK);
    bq.push_back(resp);
    S_AXI_AWADDR  <= {idx, 2'h0};
    S_AXI_WDATA   <= {r[31:8], data};
    S_AXI_WSTRB   <= strb;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= r[0];
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      // a late ready on some writes keeps the response standing
      if (S_AXI_BVALID && !S_AXI_BREADY)
        S_AXI_BREADY <= 1'b1;
    end
    while (!(S_AXI_BVALID === 1'b1 && S_AXI_BREADY === 1'b1) && n < 100);
    S_AXI_BREADY <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [5:0] idx, input logic [7:0] data, input logic [1:0] resp);
    logic [31:0] r;
    int          n;
    r = $random(seed);
    n = 0;
    @(posedge CLK);
    rq.push_back({resp, 24'h000000, data});
    S_AXI_ARADDR  <= {idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= r[0];
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID && !S_AXI_RREADY)
        S_AXI_RREADY <= 1'b1;
    end
    while (!(S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1) && n < 100);
    S_AXI_RREADY <= 1'b0;
  endtask : axi_read

  task automatic wait_active(input logic lvl, input int lim);
    int n;
    n = 0;
    while (GAIN_ACTIVE !== lvl && n < lim)
    begin
      @(posedge CLK);
      n++;
    end
  endtask : wait_active

  // one full map run with random gains and range, codes as given
  task automatic run_map(input logic [3:0] st, d01, d12, d23, d34, d45);
    logic [31:0] r;
    logic [5:0]  g [0:2];
    logic [3:0]  cd [0:5];
    logic [8:0]  base;
    r = $random(seed);
    g = '{r[17:12], r[11:6], r[5:0]};
    base = 9'h001 + {1'h0, r[25:18]};
    cd = '{st, d01, d12, d23, d34, d45};
    axi_write(IDX_START, {st, d01}, 4'h1, RESP_OKAY);
    axi_write(IDX_DELTAS_A, {d12, d23}, 4'h1, RESP_OKAY);
    axi_write(IDX_DELTAS_B, {d34, d45}, 4'h1, RESP_OKAY);
    axi_write(IDX_POINTS_A, {g[0], g[1][5:4]}, 4'h1, RESP_OKAY);
    axi_write(IDX_POINTS_B, {g[1][3:0], g[2][5:2]}, 4'h1, RESP_OKAY);
    axi_write(IDX_POINTS_C, {g[2][1:0], 6'h3F}, 4'h1, RESP_OKAY);
    axi_write(IDX_RANGE, r[25:18], 4'h1, RESP_OKAY);
    axi_read(IDX_DELTAS_B, {d34, d45}, RESP_OKAY);
    axi_read(IDX_POINTS_C, {g[2][1:0], 6'h00}, RESP_OKAY);
    for (int k = 1; k <= 6; k++)
      pq.push_back({3'(k), {3'h0, g[k < 3 ? k - 1 : 2]} + base,
                    16'(SEG_US[cd[k - 1]] * TPU - (k == 1))});
    axi_write(IDX_CONTROL, 8'h01, 4'h1, RESP_OKAY);
    wait_active(1'b1, 10);
    wait_active(1'b0, 40000);
    axi_read(IDX_CONTROL, 8'h00, RESP_OKAY);
    axi_read(IDX_STATUS, 8'h60, RESP_OKAY);
  endtask : run_map

  // ----------------------------------------
  // monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge CLK)
  begin
    if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      exp_b = bq.pop_front();
      `CHK(S_AXI_BRESP, exp_b)
    end
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      exp_r = rq.pop_front();
      `CHK({S_AXI_RRESP, S_AXI_RDATA}, exp_r)
    end
    // active shows one cycle after the map timer starts
    if (GAIN_ACTIVE === 1'b1 && last_act !== 1'b1)
      seg_len = 16'h0000;
    if (RESET_N && GAIN_POINT !== last_pt && GAIN_POINT !== 3'h0)
    begin
      exp_pt = pq.pop_front();
      `CHK(GAIN_POINT, exp_pt[27:25])
      `CHK(GAIN_HALF_DB, exp_pt[24:16])
      if (exp_pt[15:0] != 16'h0000)
        `CHK(seg_len, exp_pt[15:0])
      seg_len = 16'h0000;
    end
    last_pt = GAIN_POINT;
    last_act = GAIN_ACTIVE;
    seg_len = seg_len + 16'h0001;
  end

  task automatic print_verdict;
    num_errors += bq.size() + rq.size() + pq.size();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #(70000 * CLK_PERIOD_NS);
    num_errors++;
    print_verdict;
  end

  initial
  begin
    seed = 47585;
    num_errors = 0;
    total_checks = 0;
    {RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    for (int i = 20; i <= 25; i++)
      axi_read(6'(i), 8'h00, RESP_OKAY);
    axi_write(6'h1A, 8'hA5, 4'h1, RESP_SLVERR);
    axi_read(6'h1A, 8'h00, RESP_SLVERR);
    axi_write(IDX_POINTS_A, 8'h5A, 4'hE, RESP_OKAY);
    axi_read(IDX_POINTS_A, 8'h00, RESP_OKAY);
    axi_write(IDX_STATUS, 8'hFF, 4'h1, RESP_OKAY);
    axi_read(IDX_STATUS, 8'h00, RESP_OKAY);
    run_map(4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4);
    run_map(4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9);
    run_map(4'hA, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE);
    run_map(4'hF, 4'hF, 4'h0, 4'h1, 4'h2, 4'h3);
    // start, then start and abort together: abort must win
    axi_write(IDX_CONTROL, 8'h01, 4'h1, RESP_OKAY);
    wait_active(1'b1, 10);
    axi_write(IDX_CONTROL, 8'h03, 4'h1, RESP_OKAY);
    axi_read(IDX_STATUS, 8'h00, RESP_OKAY);
    @(posedge CLK);
    RESET_N <= 1'b0;
    @(posedge CLK);
    RESET_N <= 1'b1;
    axi_read(IDX_POINTS_B, 8'h00, RESP_OKAY);
    repeat (4) @(posedge CLK);
    print_verdict;
  end
endmodule : gain_map_regs_tb_top
